// File: inc/tic_pkg.sv
// Function
// - each channel gate spans pulse to second clock, times a common factor
// - gate starts on a clock edge, lasts 2048 times the captured interval
// - fine scalers count clocks during the gate, 4.88 ps per count
// - accepted channel stays busy, rejects pulses until cleared, shows busy
// - anticoincidence mode, no external gate: input open, pulse sets capture
// - first sync stage next clock, second stage one period later
// - charge from delayed capture until second stage; gate while comparator high
// - stop enabled through start path; selector position 1 enables both
// - start gate leading edge sets start seen, opens main count gate
// - start scaler counts whole clocks during gate, last one restored
// - start gate trailing edge stops scaler, sets start done, locks start latch
// - stop gate leading edge sets stop seen, closes main count gate
// - stop scaler to trailing edge; both done gives end of conversion out
// - after settling, two strobes of set widths with fixed gap
// - first strobe: adder bit 11 set adds one main count
// - second strobe: adder carry out adds two main counts
// - after delay every event accepted, ready starts buffer transfer
// - ready lamp lit while ready; immediate transfer gives a short blink
// - inhibit blocks starts at once; clear and stop block deferred until a running event is transferred
// - initialize clears all scalers and latches except buffer
// - buffer reset pulse or button release clears scalers and latches
// - adder forms start plus complemented stop plus one, 12 bits
// - main scaler 24 bits, start and stop scalers 12 bits
// - stop channel held cleared until main reaches stop preset
// - no stop before range preset: overrun clear resets and rearms
package tic_pkg;
  localparam int CLK_NS = 10;
  localparam int K_STRETCH = 2048;
  // two clock periods stretched by k
  localparam logic [12:0] GATE_SPAN = 13'h1000;
  localparam int SETTLE_NS = 40;
  localparam int STB1_NS = 20;
  localparam int GAP_NS = 20;
  localparam int STB2_NS = 20;
  localparam int DECIDE_NS = 40;
  localparam int BLINK_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB1_CYC = (STB1_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB2_CYC = (STB2_NS + CLK_NS - 1) / CLK_NS;
  localparam int DECIDE_CYC = (DECIDE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_CYC = (BLINK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_MAIN = 5'h08;
  localparam logic [4:0] A_FINE = 5'h0c;
  localparam logic [4:0] A_SUM = 5'h10;
  localparam int CTRL_STOP_LSB = 0;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_ANTI = 8;
  localparam int STAT_OVR = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0142;
  localparam logic [3:0] SEL_TOGETHER = 4'h1;
endpackage

// File: rtl/interp_chan.sv
`timescale 1ns/1ps
module interp_chan (
  input  wire logic        clk,    // master clock
  input  wire logic        srst,   // sync reset
  input  wire logic        clear,  // hold channel cleared
  input  wire logic        arm,    // input gate open
  input  wire logic        pulse,  // input pulse
  input  wire logic [10:0] phase,  // clock to pulse, 1/2048 period
  output logic             gate,   // stretched gate
  output logic             busy    // capture latch
);
  logic        sync1;
  logic        sync2;
  logic [12:0] span;
  wire         take = pulse & arm & ~busy;
  wire         charge = busy & ~sync2;

  // capture, two-stage sync, stretched gate
  always_ff @(posedge clk) begin
    if (srst | clear) begin
      busy <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      span <= '0;
      gate <= 1'b0;
    end else begin
      if (take) busy <= 1'b1;
      sync1 <= busy;
      sync2 <= sync1;
      if (sync1 & ~sync2) begin
        span <= tic_pkg::GATE_SPAN - {2'b00, phase};
        gate <= 1'b1;
      end else if (gate) begin
        span <= span - 13'h0001;
        gate <= (span != 13'h0001);
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst || clear);
  busy_hold_a: assert property (busy |=> busy) else $error("busy dropped");
  sync_step_a: assert property ($rose(busy) |=> sync1 && !sync2 ##1 sync2) else $error("sync order");
  gate_sync_a: assert property ($rose(sync2) |-> $rose(gate)) else $error("gate not on clock");
  charge_a: assert property (charge |-> !gate) else $error("gate during charge");
endmodule

// File: rtl/strobe_seq.sv
`timescale 1ns/1ps
module strobe_seq (
  input  wire logic clk,    // master clock
  input  wire logic srst,   // sync reset
  input  wire logic clear,  // abort sequence
  input  wire logic eoc,    // end of conversion level
  output logic      stb1,   // first strobe
  output logic      stb2,   // second strobe
  output logic      accept  // event accepted pulse
);
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_STB1, S_GAP, S_STB2, S_DECIDE} seq_e;
  seq_e       st;
  logic [7:0] cnt;
  logic       eoc_q;

  assign stb1 = (st == S_STB1);
  assign stb2 = (st == S_STB2);

  always_ff @(posedge clk) begin
    if (srst | clear) begin
      st <= S_IDLE;
      cnt <= '0;
      eoc_q <= 1'b0;
      accept <= 1'b0;
    end else begin
      eoc_q <= eoc;
      accept <= 1'b0;
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      else case (st)
        S_IDLE: if (eoc & ~eoc_q) begin
          st <= S_SETTLE;
          cnt <= 8'(tic_pkg::SETTLE_CYC - 1);
        end
        S_SETTLE: begin
          st <= S_STB1;
          cnt <= 8'(tic_pkg::STB1_CYC - 1);
        end
        S_STB1: begin
          st <= S_GAP;
          cnt <= 8'(tic_pkg::GAP_CYC - 1);
        end
        S_GAP: begin
          st <= S_STB2;
          cnt <= 8'(tic_pkg::STB2_CYC - 1);
        end
        S_STB2: begin
          st <= S_DECIDE;
          cnt <= 8'(tic_pkg::DECIDE_CYC - 1);
        end
        S_DECIDE: begin
          st <= S_IDLE;
          accept <= 1'b1;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst || clear);
  stb_width_a: assert property ($rose(stb1) |-> stb1 [*2] ##1 !stb1) else $error("strobe width");
  stb_gap_a: assert property ($fell(stb1) |-> !stb2 [*2] ##1 stb2 [*2]) else $error("strobe gap");
endmodule

// File: rtl/time_interval_count_control.sv
`timescale 1ns/1ps
module time_interval_count_control (
  input  wire logic        clk,          // master clock
  input  wire logic        srst,         // sync reset
  input  wire logic [4:0]  addr,         // register byte address
  input  wire logic [31:0] wdata,        // write data
  input  wire logic        wr,           // write strobe
  input  wire logic        rd,           // read strobe
  output logic      [31:0] rdata,        // read data, next cycle
  input  wire logic        start_pulse,  // start input pulse
  input  wire logic [10:0] start_phase,  // start offset to clock
  input  wire logic        stop_pulse,   // stop input pulse
  input  wire logic [10:0] stop_phase,   // stop offset to clock
  input  wire logic        ext_gate,     // external input gate
  input  wire logic        inhibit,      // dataway inhibit level
  input  wire logic        init,         // dataway initialize pulse
  input  wire logic        buf_reset,    // buffer transfer done pulse
  input  wire logic        clear_btn,    // manual clear button
  output logic             start_busy,   // start channel busy
  output logic             stop_busy,    // stop channel busy
  output logic             eoc_out,      // end of conversion trigger
  output logic             ready,        // event ready for buffer
  output logic      [34:0] data_word,    // main count and fine sum
  output logic             ready_lamp    // scaler ready light
);

  // control and state
  logic [31:0] ctrl;
  logic        btn_m;
  logic        btn_s;
  logic        btn_q;
  logic        clr_q;
  logic        inh_eff;
  logic        start_seen_latch;
  logic        stop_seen_latch;
  logic        start_done;
  logic        stop_done;
  logic        en_latch;
  logic        ovr_flag;
  logic        start_gate_q;
  logic        stop_gate_q;
  logic        stb1_q;
  logic        stb2_q;
  logic [23:0] main;
  logic [11:0] fine_st;
  logic [11:0] fine_sp;
  logic [7:0]  blink;
  logic        start_gate;
  logic        stop_gate;
  logic        stb1;
  logic        stb2;
  logic        acc;

  // control fields
  wire [3:0]  stop_sel = ctrl[tic_pkg::CTRL_STOP_LSB +: 4];
  wire [3:0]  range_sel = ctrl[tic_pkg::CTRL_RANGE_LSB +: 4];
  wire        anticoinc = ctrl[tic_pkg::CTRL_ANTI];
  wire [23:0] stop_preset = 24'h00_0001 << {stop_sel, 1'b0};
  wire [23:0] range_preset = 24'h00_0010 << {range_sel, 1'b0};

  // input gate open unless external gate in anticoincidence mode, open only with it otherwise
  wire in_open = anticoinc ? ~ext_gate : ext_gate;

  // inhibit blocks new starts at once
  wire start_arm = in_open & ~inhibit & ~inh_eff;
  wire stop_arm = in_open & ~inh_eff;

  wire stop_en = en_latch | (stop_sel == tic_pkg::SEL_TOGETHER);
  wire stop_clear = clr_q | ~stop_en;

  // gate edges
  wire start_rise = start_gate & ~start_gate_q;
  wire start_fall = ~start_gate & start_gate_q;
  wire stop_rise = stop_gate & ~stop_gate_q;
  wire stop_fall = ~stop_gate & stop_gate_q;

  // main gate between the two latches
  wire main_count_gate = start_seen_latch & ~stop_seen_latch;

  wire eoc = start_done & stop_done;

  // start plus inverted stop plus one
  wire [12:0] sum = {1'b0, fine_st} + {1'b0, ~fine_sp} + 13'h0001;
  wire        adder_carry_out = sum[12];

  // strobe leading edges act once each
  wire stb1_p = stb1 & ~stb1_q;
  wire stb2_p = stb2 & ~stb2_q;
  wire corr1 = stb1_p & sum[11];
  wire corr2 = stb2_p & adder_carry_out;

  wire [23:0] main_inc = {22'h00_0000, corr2, corr1 | main_count_gate};
  wire [23:0] next_main = main + main_inc;

  wire ovr_hit = main_count_gate & (main == range_preset);

  // button release from synced copy only
  wire btn_release = btn_q & ~btn_s;

  // an event runs from start seen until its transfer
  wire event_active = start_seen_latch | ready;

  wire clear_all = init | buf_reset | btn_release | ovr_hit | inh_eff;

  // register decode
  wire wr_ctrl = wr & (addr == tic_pkg::A_CTRL);
  wire wr_stat = wr & (addr == tic_pkg::A_STAT);
  wire [31:0] stat_word = {24'h00_0000, ovr_flag, inh_eff, en_latch, stop_done,
                           start_done, stop_seen_latch, start_seen_latch, ready};
  wire [31:0] rd_mux =
    (addr == tic_pkg::A_CTRL) ? ctrl :
    (addr == tic_pkg::A_STAT) ? stat_word :
    (addr == tic_pkg::A_MAIN) ? {8'h00, main} :
    (addr == tic_pkg::A_FINE) ? {4'h0, fine_sp, 4'h0, fine_st} :
    (addr == tic_pkg::A_SUM) ? {19'h0_0000, sum} :
    32'h0000_0000;

  // channels share one stretch factor
  // common factor in both
  interp_chan u_start (
    .clk   (clk),
    .srst  (srst),
    .clear (clr_q),
    .arm   (start_arm),
    .pulse (start_pulse),
    .phase (start_phase),
    .gate  (start_gate),
    .busy  (start_busy)
  );

  interp_chan u_stop (
    .clk   (clk),
    .srst  (srst),
    .clear (stop_clear),
    .arm   (stop_arm),
    .pulse (stop_pulse),
    .phase (stop_phase),
    .gate  (stop_gate),
    .busy  (stop_busy)
  );

  // settle, strobes and decision
  strobe_seq u_seq (
    .clk    (clk),
    .srst   (srst),
    .clear  (clr_q),
    .eoc    (eoc),
    .stb1   (stb1),
    .stb2   (stb2),
    .accept (acc)
  );

  always_ff @(posedge clk) begin
    btn_m <= clear_btn;
    btn_s <= btn_m;
    btn_q <= btn_s;
  end

  // clear registered to break combinational loops
  always_ff @(posedge clk) begin
    if (srst) clr_q <= 1'b0;
    else clr_q <= clear_all;
  end

  always_ff @(posedge clk) begin
    if (srst | ~inhibit) inh_eff <= 1'b0;
    else if (~event_active) inh_eff <= 1'b1;
  end

  // edge history and strobe history
  // cleared with the channels, so a gate cut by a clear is no false trailing edge
  always_ff @(posedge clk) begin
    if (srst | clr_q) begin
      start_gate_q <= 1'b0;
      stop_gate_q <= 1'b0;
      stb1_q <= 1'b0;
      stb2_q <= 1'b0;
    end else begin
      start_gate_q <= start_gate;
      stop_gate_q <= stop_gate;
      stb1_q <= stb1;
      stb2_q <= stb2;
    end
  end

  // start latch set once per event
  always_ff @(posedge clk) begin
    if (srst | clr_q) start_seen_latch <= 1'b0;
    else if (start_rise) start_seen_latch <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst | clr_q) stop_seen_latch <= 1'b0;
    else if (stop_rise) stop_seen_latch <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst | clr_q) begin
      start_done <= 1'b0;
      stop_done <= 1'b0;
    end else begin
      if (start_fall) start_done <= 1'b1;
      if (stop_fall) stop_done <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst | clr_q) en_latch <= 1'b0;
    else if (main_count_gate & (main == stop_preset)) en_latch <= 1'b1;
  end

  // whole clocks counted while gate high
  // count_pulse_reshaper: no runt pulses exist here
  always_ff @(posedge clk) begin
    if (srst | clr_q) begin
      fine_st <= '0;
      fine_sp <= '0;
    end else begin
      fine_st <= fine_st + {11'h000, start_gate};
      fine_sp <= fine_sp + {11'h000, stop_gate};
    end
  end

  always_ff @(posedge clk) begin
    if (srst | clr_q) main <= '0;
    else main <= next_main;
  end

  always_ff @(posedge clk) begin
    if (srst) eoc_out <= 1'b0;
    else eoc_out <= eoc & ~clr_q;
  end

  always_ff @(posedge clk) begin
    if (srst | clr_q) ready <= 1'b0;
    else if (acc) ready <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) data_word <= '0;
    else if (acc) data_word <= {main, sum[10:0]};
  end

  always_ff @(posedge clk) begin
    if (srst) blink <= '0;
    else if (acc) blink <= 8'(tic_pkg::BLINK_CYC);
    else if (blink != 8'h00) blink <= blink - 8'h01;
  end

  // lamp lit while ready or blinking
  always_ff @(posedge clk) begin
    if (srst) ready_lamp <= 1'b0;
    else ready_lamp <= ready | (blink != 8'h00);
  end

  // control register, range and stop selectors
  always_ff @(posedge clk) begin
    if (srst) ctrl <= tic_pkg::CTRL_RST;
    else if (wr_ctrl) ctrl <= {23'h00_0000, wdata[8:0]};
  end

  // overrun flag, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) ovr_flag <= 1'b0;
    else if (ovr_hit) ovr_flag <= 1'b1;
    else if (wr_stat & wdata[tic_pkg::STAT_OVR]) ovr_flag <= 1'b0;
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) rdata <= '0;
    else rdata <= rd ? rd_mux : 32'h0000_0000;
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence cleared_s;
    ##2 (main == 24'h00_0000 && !start_seen_latch && !ready);
  endsequence

  sequence quiet_s;
    !clr_q && !stb1_p && !stb2_p;
  endsequence

  start_latch_a: assert property (
    start_rise && !clr_q |=> start_seen_latch && main_count_gate == !stop_seen_latch)
    else $error("start latch not set");

  main_count_a: assert property (
    (main_count_gate and quiet_s) |=> main == $past(main) + 24'h00_0001)
    else $error("main not counting");

  main_hold_a: assert property (
    (stop_seen_latch and quiet_s) |=> main == $past(main))
    else $error("main counted after stop");

  start_done_a: assert property (
    start_fall && !clr_q |=> start_done && fine_st == $past(fine_st))
    else $error("start done missing");

  eoc_out_a: assert property (
    eoc && !clr_q |=> eoc_out)
    else $error("no end of conversion out");

  corr_one_a: assert property (
    corr1 && !clr_q |=> main == $past(main) + 24'h00_0001)
    else $error("first correction wrong");

  corr_two_a: assert property (
    corr2 && !clr_q |=> main == $past(main) + 24'h00_0002)
    else $error("second correction wrong");

  ready_set_a: assert property (
    acc && !clr_q |=> ready && data_word[10:0] == $past(sum[10:0]))
    else $error("ready not raised");

  ready_lamp_a: assert property (
    ready |=> ready_lamp)
    else $error("lamp dark while ready");

  buf_clear_a: assert property (
    buf_reset |-> cleared_s)
    else $error("buffer reset did not clear");

  inhibit_a: assert property (
    inh_eff |-> cleared_s)
    else $error("inhibit did not clear");

  stop_hold_a: assert property (
    !stop_en |=> !stop_gate)
    else $error("stop ran while disabled");

  overrun_a: assert property (
    ovr_hit |-> ##2 (main == 24'h00_0000 && !start_busy))
    else $error("overrun did not clear");

endmodule

// File: testbench/buffer_reg_model.sv
`timescale 1ns/1ps
module buffer_reg_model (
  input  wire logic        clk,        // master clock
  input  wire logic        srst,       // sync reset
  input  wire logic        ready,      // event ready from scalers
  input  wire logic [34:0] data_word,  // word to capture
  input  wire logic        hold,       // buffer still busy, stall
  output logic             buf_reset,  // transfer done pulse
  output logic      [34:0] stored,     // captured word
  output logic             taken       // word taken this event
);
  logic [1:0] dly;

  // capture, then pulse back
  // one pulse per ready, so a slow clear never retriggers a transfer
  always_ff @(posedge clk) begin
    buf_reset <= 1'b0;
    if (srst) begin
      dly <= 2'd0;
      taken <= 1'b0;
      stored <= '0;
    end else if (!ready) begin
      dly <= 2'd0;
      taken <= 1'b0;
    end else if (!hold && !taken) begin
      dly <= dly + 2'd1;
      if (dly == 2'd2) begin
        stored <= data_word;
        taken <= 1'b1;
        buf_reset <= 1'b1;
      end
    end
  end
endmodule

// File: testbench/time_interval_count_control_tb.sv
`timescale 1ns/1ps
module time_interval_count_control_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        start_pulse = 1'b0;
  logic [10:0] start_phase = 11'h000;
  logic        stop_pulse = 1'b0;
  logic [10:0] stop_phase = 11'h000;
  logic        ext_gate = 1'b0;
  logic        inhibit = 1'b0;
  logic        init = 1'b0;
  logic        buf_reset;
  logic        clear_btn = 1'b0;
  logic        start_busy;
  logic        stop_busy;
  logic        eoc_out;
  logic        ready;
  logic [34:0] data_word;
  logic        ready_lamp;
  logic        hold = 1'b1;
  logic [34:0] stored;
  logic [31:0] rv;
  int          error_cnt = 0;
  int          tests_run = 0;

  // free-running 100 MHz master clock
  always #5 clk = ~clk;

  time_interval_count_control time_interval_count_control_inst (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .start_pulse(start_pulse), .start_phase(start_phase), .stop_pulse(stop_pulse),
    .stop_phase(stop_phase), .ext_gate(ext_gate), .inhibit(inhibit), .init(init),
    .buf_reset(buf_reset), .clear_btn(clear_btn), .start_busy(start_busy), .stop_busy(stop_busy),
    .eoc_out(eoc_out), .ready(ready), .data_word(data_word), .ready_lamp(ready_lamp)
  );

  buffer_reg_model buffer_reg_model_inst (
    .clk(clk), .srst(srst), .ready(ready), .data_word(data_word), .hold(hold),
    .buf_reset(buf_reset), .stored(stored), .taken()
  );

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data is only valid in the cycle right after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // pulse one channel input; the accept edge is the task's last edge
  task automatic fire(input bit stp, input logic [10:0] ph);
    @(posedge clk);
    if (stp) begin
      stop_pulse <= 1'b1;
      stop_phase <= ph;
    end else begin
      start_pulse <= 1'b1;
      start_phase <= ph;
    end
    @(posedge clk);
    start_pulse <= 1'b0;
    stop_pulse <= 1'b0;
  endtask

  task automatic wait_ready(input logic lvl, input int lim);
    int n;
    n = 0;
    while (ready !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (ready !== lvl) begin
      error_cnt++;
      $display("[ERR] %0t ready wait ran out", $time);
      print_verdict();
    end
  endtask

  // expected word from fine counts, complemented stop and both corrections
  task automatic check_event(input logic [10:0] pa, input logic [10:0] pb, input int d);
    logic [11:0] st;
    logic [11:0] sp;
    logic [12:0] sum;
    logic [23:0] mn;
    st = 12'(13'h1000 - 13'(pa));
    sp = 12'(13'h1000 - 13'(pb));
    sum = {1'b0, st} + {1'b0, ~sp} + 13'h0001;
    mn = 24'(d) + 24'(sum[11]) + 24'({sum[12], 1'b0});
    wait_ready(1'b1, 10000);
    check(eoc_out, 1'b1);
    check(data_word, {mn, sum[10:0]});
    reg_rd(tic_pkg::A_FINE, rv);
    check(rv, {4'h0, sp, 4'h0, st});
    reg_rd(tic_pkg::A_SUM, rv);
    check(rv, 32'(sum));
    reg_rd(tic_pkg::A_MAIN, rv);
    check(rv, {8'h00, mn});
    check(ready_lamp, 1'b1);
    @(posedge clk);
    hold <= 1'b0;
    wait_ready(1'b0, 20);
    check(stored, {mn, sum[10:0]});
    check({start_busy, stop_busy}, 2'b00);
    check(ready_lamp, 1'b1);
    repeat (250) @(posedge clk);
    check(ready_lamp, 1'b0);
    @(posedge clk);
    hold <= 1'b1;
  endtask

  // a hung handshake still ends in the closing report
  initial begin
    #1_000_000;
    error_cnt++;
    $display("[ERR] %0t run too long", $time);
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({start_busy, stop_busy, eoc_out, ready, ready_lamp, data_word}, 40'h00_0000_0000);
    reg_rd(tic_pkg::A_CTRL, rv);
    check(rv, tic_pkg::CTRL_RST);
    reg_rd(5'h14, rv);
    check(rv, 32'h0000_0000);
    reg_wr(tic_pkg::A_MAIN, 32'h0000_0123);
    reg_rd(tic_pkg::A_MAIN, rv);
    check(rv, 32'h0000_0000);
    reg_wr(tic_pkg::A_CTRL, 32'h0000_0191);
    reg_rd(tic_pkg::A_CTRL, rv);
    check(rv, 32'h0000_0191);
    $display("test reset done");

    // both channels armed together; a second start while busy is ignored
    fire(1'b0, 11'h064);
    fire(1'b0, 11'h064);
    #1 check(start_busy, 1'b1);
    repeat (3) @(posedge clk);
    fire(1'b1, 11'h12c);
    check_event(11'h064, 11'h12c, 7);
    $display("test together done");

    // stop held off until the preset, inhibit raised mid event
    reg_wr(tic_pkg::A_CTRL, 32'h0000_0192);
    fire(1'b0, 11'h12c);
    repeat (3) @(posedge clk);
    fire(1'b1, 11'h000);
    repeat (2) @(posedge clk);
    #1 check(stop_busy, 1'b0);
    repeat (31) @(posedge clk);
    fire(1'b1, 11'h064);
    @(posedge clk);
    inhibit <= 1'b1;
    check_event(11'h12c, 11'h064, 40);
    reg_rd(tic_pkg::A_STAT, rv);
    check(rv, 32'h0000_0040);
    fire(1'b0, 11'h010);
    repeat (3) @(posedge clk);
    #1 check(start_busy, 1'b0);
    @(posedge clk);
    inhibit <= 1'b0;
    $display("test preset and inhibit done");

    // no stop within the shortest range
    reg_wr(tic_pkg::A_CTRL, 32'h0000_0101);
    fire(1'b0, 11'h000);
    repeat (30) @(posedge clk);
    #1 check(start_busy, 1'b0);
    reg_rd(tic_pkg::A_STAT, rv);
    check(rv, 32'h0000_0080);
    reg_wr(tic_pkg::A_STAT, 32'h0000_0080);
    reg_rd(tic_pkg::A_STAT, rv);
    check(rv, 32'h0000_0000);
    $display("test overrun done");

    // closed input gate, then initialize and button release
    reg_wr(tic_pkg::A_CTRL, 32'h0000_0191);
    @(posedge clk);
    ext_gate <= 1'b1;
    fire(1'b0, 11'h010);
    repeat (3) @(posedge clk);
    #1 check(start_busy, 1'b0);
    @(posedge clk);
    ext_gate <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      fire(1'b0, 11'h010);
      repeat (2) @(posedge clk);
      #1 check(start_busy, 1'b1);
      @(posedge clk);
      init <= (i == 0);
      clear_btn <= (i == 1);
      @(posedge clk);
      init <= 1'b0;
      repeat (3) @(posedge clk);
      clear_btn <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check(start_busy, 1'b0);
    end
    // coincidence mode opens the input only while the gate is high
    reg_wr(tic_pkg::A_CTRL, 32'h0000_0091);
    fire(1'b0, 11'h010);
    repeat (3) @(posedge clk);
    #1 check(start_busy, 1'b0);
    @(posedge clk);
    ext_gate <= 1'b1;
    fire(1'b0, 11'h010);
    #1 check(start_busy, 1'b1);
    $display("test clears done");
    print_verdict();
  end
endmodule
